// ==== hdl/iswk_defs.svh ====
// Summary of operation
// [RULE_01] port pins in output mode still raise their flag when level changes
// [RULE_02] software writes zero to unused edge-mode bits 0, 1, 6 and 7
// [RULE_03] software masks, writes edge mode, clears flag, then unmasks
// [RULE_04] no acknowledge while flag or mask registers are being accessed
// [RULE_05] a new request is acknowledged during servicing, even if low priority
// [RULE_06] slow oscillator stop bit obeyed only when option byte allows it
// [RULE_07] software halts non slow-clock peripherals before executing stop
// [RULE_08] slow oscillator running at stop entry keeps running throughout stop
// [RULE_09] pending unmasked request releases halt or stop, or blocks entry
// [RULE_10] stop release holds operation stopped for 34 us before resuming
`ifndef ISWK_DEFS_SVH
`define ISWK_DEFS_SVH

`define ISWK_SRC_NUM      8
`define ISWK_EXT_A_BIT    3'h0
`define ISWK_EXT_B_BIT    3'h1
`define ISWK_FLAGS_RST    8'h00
`define ISWK_MASK_RST     8'hff
`define ISWK_EDGE_RST     8'h00
`define ISWK_EDGE_USED    8'h3c
`define ISWK_EDGE_A_LSB   2
`define ISWK_EDGE_B_LSB   4
`define ISWK_CLK_MHZ      100
`define ISWK_SETTLE_US    34
`define ISWK_SETTLE_CYC   (`ISWK_SETTLE_US * `ISWK_CLK_MHZ)

`endif

// ==== hdl/iswk_pkg.sv ====
package iswk_pkg;

  typedef enum logic [1:0] {
    ISWK_RUN    = 2'h0,
    ISWK_HALT   = 2'h1,
    ISWK_STOP   = 2'h3,
    ISWK_SETTLE = 2'h2
  } iswk_state_e;

  // software side of the flag, mask and edge-mode registers
  typedef struct packed {
    logic       access;
    logic       wr_flags;
    logic       wr_mask;
    logic       wr_edge;
    logic [7:0] data;
  } iswk_sw_s;

  // one port pin that doubles as an external interrupt input
  typedef struct packed {
    logic pin;
    logic out_mode;
    logic out_level;
  } iswk_pin_s;

endpackage

// ==== hdl/iswk_edge_det.sv ====
`timescale 1ns/10ps
module iswk_edge_det
  import iswk_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire iswk_pin_s  port,
  input  wire logic [1:0] mode,
  output logic            event_o
);

  logic level;
  logic prev_reg;
  logic valid_reg;

  // [RULE_01] output drive seen
  // the driven level is what the detector sees, so output toggles still count
  assign level = port.out_mode ? port.out_level : port.pin;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg  <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      prev_reg  <= level;
      valid_reg <= 1'b1;
    end
  end

  // mode: 00 falling, 01 rising, 1x both edges
  // first cycle after reset has no history, so no event
  always_comb begin
    event_o = 1'b0;
    if (valid_reg) begin
      unique case (mode)
        2'h0:    event_o = prev_reg & ~level;
        2'h1:    event_o = ~prev_reg & level;
        default: event_o = prev_reg ^ level;
      endcase
    end
  end

endmodule // iswk_edge_det

// ==== hdl/iswk_top.sv ====
`timescale 1ns/10ps
`include "iswk_defs.svh"
module iswk_top
  import iswk_pkg::*;
#(
  parameter int SETTLE_CYC = `ISWK_SETTLE_CYC
)(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [7:0] periph_irq,
  input  wire iswk_pin_s  ext_irq_port_a,
  input  wire iswk_pin_s  ext_irq_port_b,
  input  wire iswk_sw_s   sw,
  input  wire logic       irq_ack,
  input  wire logic       halt_cmd,
  input  wire logic       stop_cmd,
  input  wire logic       opt_slow_osc_sw_stop,
  input  wire logic       slow_osc_stop_ctl,
  output logic [7:0]      irq_request_flags,
  output logic [7:0]      irq_mask_flags,
  output logic [7:0]      ext_irq_edge_mode,
  output logic            irq_req,
  output logic [2:0]      irq_id,
  output logic            cpu_run,
  output logic            main_clk_run,
  output logic            slow_osc_run,
  output logic [1:0]      standby_state
);

  logic              rst_meta_reg;
  logic              rst_n;
  logic              ext_a_evt;
  logic              ext_b_evt;
  logic [7:0]        events;
  logic [7:0]        pending;
  logic              wake;
  logic [2:0]        top_id;
  logic [7:0]        ack_clr;
  logic [7:0]        flags_next;
  iswk_state_e       state_reg;
  iswk_state_e       state_next;
  logic [11:0]       settle_cnt_reg;
  logic              slow_keep_reg;

  // reset released through two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  iswk_edge_det u_edge_a (
    .clk     (clk),
    .rst_n   (rst_n),
    .port    (ext_irq_port_a),
    .mode    (ext_irq_edge_mode[`ISWK_EDGE_A_LSB +: 2]),
    .event_o (ext_a_evt)
  );

  iswk_edge_det u_edge_b (
    .clk     (clk),
    .rst_n   (rst_n),
    .port    (ext_irq_port_b),
    .mode    (ext_irq_edge_mode[`ISWK_EDGE_B_LSB +: 2]),
    .event_o (ext_b_evt)
  );

  // external pins share their slots with peripheral lines
  always_comb begin
    events                  = periph_irq;
    events[`ISWK_EXT_A_BIT] = periph_irq[`ISWK_EXT_A_BIT] | ext_a_evt;
    events[`ISWK_EXT_B_BIT] = periph_irq[`ISWK_EXT_B_BIT] | ext_b_evt;
  end

  // lowest index wins; used for both acknowledge and id
  function automatic logic [2:0] first_set(input logic [7:0] v);
    first_set = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 3'(i);
      end
    end
  endfunction

  assign pending = irq_request_flags & ~irq_mask_flags;
  assign wake    = |pending;
  assign top_id  = first_set(pending);
  assign ack_clr = irq_ack ? (8'h01 << irq_id) : 8'h00;

  // a new event in the clearing cycle survives
  always_comb begin
    flags_next = irq_request_flags & ~ack_clr;
    if (sw.wr_flags) begin
      flags_next = sw.data;
    end
    flags_next = flags_next | events;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_request_flags <= `ISWK_FLAGS_RST;
    end else begin
      irq_request_flags <= flags_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_flags <= `ISWK_MASK_RST;
    end else if (sw.wr_mask) begin
      irq_mask_flags <= sw.data;
    end
  end

  // [RULE_02] unused bits dropped
  // stray writes to reserved bits cannot select a mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_irq_edge_mode <= `ISWK_EDGE_RST;
    end else if (sw.wr_edge) begin
      ext_irq_edge_mode <= sw.data & `ISWK_EDGE_USED;
    end
  end

  // [RULE_04] hold during access
  // [RULE_05] no in-service block
  // request drops for one cycle after an ack so the same id is not taken twice
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= 1'b0;
      irq_id  <= 3'h0;
    end else begin
      irq_req <= wake & ~sw.access & ~irq_ack & (state_reg == ISWK_RUN);
      irq_id  <= top_id;
    end
  end

  // [RULE_09] wake or refuse entry
  // [RULE_10] settle after stop
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ISWK_RUN: begin
        if (stop_cmd) begin
          state_next = wake ? ISWK_SETTLE : ISWK_STOP;
        end else if (halt_cmd && !wake) begin
          state_next = ISWK_HALT;
        end
      end
      ISWK_HALT: begin
        if (wake) begin
          state_next = ISWK_RUN;
        end
      end
      ISWK_STOP: begin
        if (wake) begin
          state_next = ISWK_SETTLE;
        end
      end
      ISWK_SETTLE: begin
        if (settle_cnt_reg == 12'h000) begin
          state_next = ISWK_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ISWK_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt_reg <= 12'h000;
    end else if (state_reg != ISWK_SETTLE) begin
      settle_cnt_reg <= 12'(SETTLE_CYC - 1);
    end else if (settle_cnt_reg != 12'h000) begin
      settle_cnt_reg <= settle_cnt_reg - 12'h001;
    end
  end

  // [RULE_08] keep slow clock in stop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_keep_reg <= 1'b0;
    end else if (state_reg == ISWK_RUN && state_next == ISWK_STOP) begin
      slow_keep_reg <= slow_osc_run;
    end else if (state_reg == ISWK_RUN) begin
      slow_keep_reg <= 1'b0;
    end
  end

  // [RULE_06] stop bit gated
  // [RULE_08] running at entry stays on
  // entry edge counts too, before the keep flag has caught up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_osc_run <= 1'b1;
    end else if ((slow_keep_reg || (state_reg == ISWK_RUN && slow_osc_run)) &&
                 state_next == ISWK_STOP) begin
      slow_osc_run <= 1'b1;
    end else begin
      slow_osc_run <= ~(opt_slow_osc_sw_stop & slow_osc_stop_ctl);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_run       <= 1'b1;
      main_clk_run  <= 1'b1;
      standby_state <= 2'h0;
    end else begin
      cpu_run       <= (state_next == ISWK_RUN);
      main_clk_run  <= (state_next == ISWK_RUN) || (state_next == ISWK_HALT);
      standby_state <= state_next;
    end
  end

  // [RULE_01] driven pin sets flag
  ext_out_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_01]
    ext_irq_port_a.out_mode && $past(ext_irq_port_a.out_mode) && $past(rst_n) &&
    (ext_irq_edge_mode[`ISWK_EDGE_A_LSB + 1] ?
      (ext_irq_port_a.out_level != $past(ext_irq_port_a.out_level)) :
      (ext_irq_port_a.out_level == ext_irq_edge_mode[`ISWK_EDGE_A_LSB] &&
       $past(ext_irq_port_a.out_level) != ext_irq_edge_mode[`ISWK_EDGE_A_LSB]))
    |=> irq_request_flags[`ISWK_EXT_A_BIT])
    else $error("output toggle on port a did not set its flag");

  // [RULE_04] no request in access
  access_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_04]
    sw.access |=> !irq_req)
    else $error("request raised during flag or mask access");

  // [RULE_05] nested acknowledge
  nested_ack_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_05]
    state_reg == ISWK_RUN && wake && !sw.access && !irq_ack |=> irq_req)
    else $error("pending unmasked request not offered");

  // [RULE_06] stop bit gated
  osc_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_06]
    !opt_slow_osc_sw_stop |=> slow_osc_run)
    else $error("slow oscillator stopped without option permission");

  // [RULE_08] slow clock kept
  stop_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_08]
    state_reg == ISWK_STOP && slow_keep_reg |-> slow_osc_run)
    else $error("slow oscillator stopped during stop mode");

  // [RULE_09] halt wake
  halt_wake_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_09]
    state_reg == ISWK_HALT && wake |=> state_reg == ISWK_RUN && cpu_run)
    else $error("halt not released by pending request");

  // [RULE_09] entry refused
  entry_block_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_09]
    state_reg == ISWK_RUN && (halt_cmd || stop_cmd) && wake |=>
    state_reg != ISWK_HALT && state_reg != ISWK_STOP)
    else $error("standby entered with a request pending");

  // [RULE_10] settle length
  settle_end_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_10]
    $rose(state_reg == ISWK_SETTLE) |-> settle_cnt_reg == 12'(SETTLE_CYC - 1)
    ##1 (state_reg == ISWK_SETTLE && !cpu_run))
    else $error("settle interval started with wrong count");

  settle_exit_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_10]
    state_reg == ISWK_SETTLE && settle_cnt_reg == 12'h000 |=> state_reg == ISWK_RUN)
    else $error("settle interval did not end at zero");

  halt_wake_c: cover property (@(posedge clk) disable iff (!rst_n)
    state_reg == ISWK_HALT ##1 state_reg == ISWK_RUN);
  stop_settle_c: cover property (@(posedge clk) disable iff (!rst_n)
    state_reg == ISWK_STOP ##1 state_reg == ISWK_SETTLE);
  ack_c: cover property (@(posedge clk) disable iff (!rst_n)
    irq_req ##1 irq_ack);

endmodule // iswk_top

// ==== verif/iswk_core_model.sv ====
`timescale 1ns/10ps
module iswk_core_model (
  input  wire logic       clk,
  input  wire logic       en,
  input  wire logic [3:0] dly,
  input  wire logic       irq_req,
  output logic            irq_ack
);
  logic [3:0] cnt_reg = 4'h0;

  initial irq_ack = 1'b0;

  // one-cycle ack after dly waiting cycles; a slow core leaves requests stacked
  always @(posedge clk) begin
    irq_ack <= 1'b0;
    if (en && irq_req && !irq_ack) begin
      if (cnt_reg >= dly) begin
        irq_ack <= 1'b1;
        cnt_reg <= 4'h0;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule // iswk_core_model

// ==== verif/iswk_top_tb.sv ====
`timescale 1ns/10ps
module iswk_top_tb;
  import iswk_pkg::*;
  localparam int SC = 8;
  logic        clk = 1'b0, rstn = 1'b0, halt_cmd = 1'b0, stop_cmd = 1'b0;
  logic        opt = 1'b0, ctl = 1'b0, en = 1'b1, quiet = 1'b0;
  logic [3:0]  dly = 4'h0;
  logic [7:0]  periph_irq = 8'h00;
  iswk_pin_s   pa = '0, pb = '0;
  iswk_sw_s    sw = '0;
  logic        irq_ack, irq_req, cpu_run, main_clk_run, slow_osc_run;
  logic [7:0]  flags, mask, edge_mode;
  logic [2:0]  irq_id;
  logic [1:0]  state;
  logic [2:0]  exp_q[$];
  logic [31:0] rnd = 32'd22078;
  int          err_total = 0;
  int          comparisons = 0;
  int          n;

  always #5 clk = ~clk;

  iswk_top #(.SETTLE_CYC(SC)) i_dut (.clk(clk), .rstn(rstn), .periph_irq(periph_irq),
    .ext_irq_port_a(pa), .ext_irq_port_b(pb), .sw(sw), .irq_ack(irq_ack),
    .halt_cmd(halt_cmd), .stop_cmd(stop_cmd), .opt_slow_osc_sw_stop(opt),
    .slow_osc_stop_ctl(ctl), .irq_request_flags(flags), .irq_mask_flags(mask),
    .ext_irq_edge_mode(edge_mode), .irq_req(irq_req), .irq_id(irq_id), .cpu_run(cpu_run),
    .main_clk_run(main_clk_run), .slow_osc_run(slow_osc_run), .standby_state(state));

  iswk_core_model i_core (.clk(clk), .en(en), .dly(dly), .irq_req(irq_req), .irq_ack(irq_ack));

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (err_total == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [2:0] w, input logic [7:0] d);
    @(posedge clk);
    sw <= '{1'b0, w[2], w[1], w[0], d};
    @(posedge clk);
    sw <= '0;
    cyc(1);
  endtask

  // k[0] halt, k[1] stop, p low nibble peripheral pulses
  task automatic hit(input logic [1:0] k, input logic [3:0] p);
    @(posedge clk);
    halt_cmd <= k[0];
    stop_cmd <= k[1];
    periph_irq[3:0] <= p;
    @(posedge clk);
    halt_cmd <= 1'b0;
    stop_cmd <= 1'b0;
    periph_irq[3:0] <= 4'h0;
    #1;
  endtask

  task automatic wst(input logic [1:0] s);
    for (int i = 0; i < 200 && state !== s; i++) cyc(1);
    chk({6'h0, state}, {6'h0, s});
  endtask

  task automatic drain();
    for (int i = 0; i < 200 && exp_q.size() != 0; i++) cyc(1);
    chk(8'(exp_q.size()), 8'h00);
  endtask

  // upper sources and port b stay masked; they only add background noise
  always @(posedge clk) begin
    rnd = xs(rnd);
    periph_irq[7:4] <= quiet ? 4'h0 : rnd[3:0];
    pb.pin <= rnd[4];
    pb.out_mode <= rnd[5];
    pb.out_level <= rnd[6];
  end

  always @(posedge clk)
    if (irq_ack === 1'b1 && irq_req === 1'b1) begin
      if (exp_q.size() == 0) chk(8'h01, 8'h00);
      else chk({5'h0, irq_id}, {5'h0, exp_q.pop_front()});
    end

  initial begin
    #100us;
    err_total++;
    end_sim();
  end

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    cyc(4);
    chk(mask, 8'hff);
    chk(edge_mode, 8'h00);
    chk({cpu_run, main_clk_run, slow_osc_run, 3'h0, state}, 8'he0);
    // port a rising edge; unused edge bits written as zero
    wr(3'h1, 8'h04);
    chk(edge_mode, 8'h04);
    wr(3'h4, 8'h00);
    wr(3'h2, 8'hf2);
    chk(mask, 8'hf2);
    @(posedge clk);
    pa <= '{1'b0, 1'b1, 1'b0};
    cyc(3);
    exp_q.push_back(3'h0);
    @(posedge clk);
    pa.out_level <= 1'b1;
    drain();
    @(posedge clk);
    sw.access <= 1'b1;
    hit(2'h0, 4'h4);
    cyc(3);
    chk({7'h0, irq_req}, 8'h00);
    chk(flags & 8'h0d, 8'h04);
    exp_q.push_back(3'h2);
    @(posedge clk);
    sw.access <= 1'b0;
    drain();
    dly <= 4'h3;
    exp_q.push_back(3'h2);
    exp_q.push_back(3'h3);
    hit(2'h0, 4'hc);
    drain();
    dly <= 4'h0;
    quiet <= 1'b1;
    hit(2'h1, 4'h0);
    chk({cpu_run, main_clk_run, 4'h0, state}, 8'h41);
    exp_q.push_back(3'h3);
    hit(2'h0, 4'h8);
    drain();
    chk({6'h0, state}, 8'h00);
    opt <= 1'b1;
    hit(2'h2, 4'h0);
    chk({cpu_run, main_clk_run, 4'h0, state}, 8'h03);
    @(posedge clk);
    ctl <= 1'b1;
    cyc(4);
    chk({7'h0, slow_osc_run}, 8'h01);
    exp_q.push_back(3'h3);
    hit(2'h0, 4'h8);
    wst(2'h2);
    for (n = 0; n < 50 && state === 2'h2; n++) cyc(1);
    chk(8'(n), 8'(SC));
    cyc(2);
    chk({7'h0, slow_osc_run}, 8'h00);
    drain();
    @(posedge clk);
    opt <= 1'b0;
    cyc(3);
    chk({7'h0, slow_osc_run}, 8'h01);
    @(posedge clk);
    en <= 1'b0;
    ctl <= 1'b0;
    hit(2'h0, 4'h8);
    cyc(2);
    hit(2'h1, 4'h0);
    chk({6'h0, state}, 8'h00);
    hit(2'h2, 4'h0);
    chk({6'h0, state}, 8'h02);
    exp_q.push_back(3'h3);
    @(posedge clk);
    en <= 1'b1;
    wst(2'h0);
    drain();
    // peripheral line shares slot 0 with port a
    exp_q.push_back(3'h0);
    hit(2'h0, 4'h1);
    drain();
    wr(3'h2, 8'hf3);
    wr(3'h1, 8'h0c);
    wr(3'h4, 8'h00);
    wr(3'h2, 8'hf2);
    chk(edge_mode, 8'h0c);
    exp_q.push_back(3'h0);
    @(posedge clk);
    pa.out_level <= 1'b0;
    drain();
    exp_q.push_back(3'h0);
    @(posedge clk);
    pa.out_level <= 1'b1;
    drain();
    // falling edge only on port a
    wr(3'h2, 8'hf3);
    wr(3'h1, 8'h00);
    wr(3'h4, 8'h00);
    wr(3'h2, 8'hf2);
    exp_q.push_back(3'h0);
    @(posedge clk);
    pa.out_level <= 1'b0;
    drain();
    @(posedge clk);
    pa.out_level <= 1'b1;
    cyc(3);
    chk(flags & 8'h01, 8'h00);
    end_sim();
  end
endmodule // iswk_top_tb
